// >>> rtl/upr_clock_top.sv
// usb pll branches, reference clock output and wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module upr_clock_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        primary_osc_i,
  input  wire logic        pll_out_i,
  input  wire logic        sleep_i,
  output logic             pll_ref_tick_o,
  output logic             usb_clk_o,
  output logic             sys_tick_o,
  output logic             refclk_output_pin_o,
  output logic             half_rate_clock_output_o
);
  import upr_pkg::*;

  // ==========================================================================
  // bus decode
  logic           req;
  logic           wr;
  logic           wr_osc;
  logic           wr_hi;
  logic           wr_lo;
  logic           wr_other;
  upr_ref_ctrl_t  ref_q;
  logic [2:0]     pre_sel_q;
  logic [1:0]     post_sel_q;
  logic [2:0]     rc_sel_q;
  logic           usb_en_q;
  logic           half_en_q;
  upr_osc_state_t osc;

  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr       = req && wb_we_i;
  assign wr_osc   = wr && wb_adr_i == ADDR_OSC_CTRL;
  assign wr_hi    = wr_osc && wb_sel_i[1];
  assign wr_lo    = wr_osc && wb_sel_i[0];
  assign wr_other = wr && !wr_osc;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ==========================================================================
  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= '0; // R18
    end else if (wr && wb_adr_i == ADDR_REF_CTRL && wb_sel_i[1]) begin
      ref_q.out_en       <= wb_dat_i[REF_EN_BIT];
      ref_q.run_in_sleep <= wb_dat_i[REF_SLP_BIT];
      ref_q.src_primary  <= wb_dat_i[REF_SRC_BIT];
      ref_q.divisor_sel  <= wb_dat_i[REF_DIV_LSB +: 4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_sel_q  <= 3'h0;
      post_sel_q <= 2'h0;
      rc_sel_q   <= 3'h0;
      usb_en_q   <= 1'b0;
      half_en_q  <= 1'b0;
    end else if (wr && wb_adr_i == ADDR_CLK_CFG) begin
      if (wb_sel_i[0]) begin
        pre_sel_q  <= wb_dat_i[CFG_PRE_LSB +: 3]; // R10
        post_sel_q <= wb_dat_i[CFG_POST_LSB +: 2]; // R8
      end
      if (wb_sel_i[1]) begin
        rc_sel_q  <= wb_dat_i[CFG_RC_LSB +: 3];
        usb_en_q  <= wb_dat_i[CFG_USB_BIT];
        half_en_q <= wb_dat_i[CFG_HALF_BIT];
      end
    end
  end

  upr_osc_unlock u_unlock (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_hi_i    (wr_hi),
    .wr_lo_i    (wr_lo),
    .wr_other_i (wr_other),
    .hi_byte_i  (wb_dat_i[15:8]),
    .lo_byte_i  (wb_dat_i[7:0]),
    .state_o    (osc)
  );

  // ==========================================================================
  // register reads; unmapped offsets read zero and are still acknowledged
  logic        usb_ok;
  logic        pll_seen_q;
  logic [31:0] rd;

  always_comb begin
    rd = 32'h0000_0000;
    if (wb_adr_i == ADDR_OSC_CTRL) begin
      rd[OSC_CUR_LSB +: 3] = osc.cur_osc;
      rd[OSC_NEW_LSB +: 3] = osc.new_osc;
      rd[0]                = osc.switch_req;
    end else if (wb_adr_i == ADDR_REF_CTRL) begin
      rd[REF_EN_BIT]         = ref_q.out_en; // R18
      rd[REF_SLP_BIT]        = ref_q.run_in_sleep;
      rd[REF_SRC_BIT]        = ref_q.src_primary;
      rd[REF_DIV_LSB +: 4]   = ref_q.divisor_sel;
    end else if (wb_adr_i == ADDR_CLK_CFG) begin
      rd[CFG_PRE_LSB +: 3]  = pre_sel_q;
      rd[CFG_POST_LSB +: 2] = post_sel_q;
      rd[CFG_RC_LSB +: 3]   = rc_sel_q;
      rd[CFG_USB_BIT]       = usb_en_q;
      rd[CFG_HALF_BIT]      = half_en_q;
    end else if (wb_adr_i == ADDR_STATUS) begin
      rd[0] = usb_ok;
      rd[1] = pll_seen_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd;
    end
  end

  // ==========================================================================
  // pin synchronisers, one generate block per bit
  logic [1:0] pin_in;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] rise;

  assign pin_in = {pll_out_i, primary_osc_i};

  // stage one is read by stage two alone; stage three only serves edge detect
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
    assign rise[i] = s2_q[i] && !s3_q[i];
  end

  // ==========================================================================
  // pll input prescaler; no frequency sensing, divisor is software's to match
  logic [3:0] pre_cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_q      <= 4'h0;
      pll_ref_tick_o <= 1'b0;
    end else begin
      pll_ref_tick_o <= 1'b0;
      if (rise[0]) begin
        if (pre_cnt_q >= upr_pre_last(pre_sel_q)) begin // R10
          pre_cnt_q      <= 4'h0;
          pll_ref_tick_o <= 1'b1; // R5
        end else begin
          pre_cnt_q <= pre_cnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_seen_q <= 1'b0;
    end else if (rise[1]) begin
      pll_seen_q <= 1'b1;
    end
  end

  // ==========================================================================
  // usb branch: only with the primary oscillator through the pll
  assign usb_ok = usb_en_q && osc.cur_osc == OSC_PRI_PLL; // R11

  always_ff @(posedge clk_i) begin
    // low while not allowed, so a source switch can cut a high phase short
    if (rst_i || !usb_ok) begin
      usb_clk_o <= 1'b0;
    end else if (rise[1]) begin
      usb_clk_o <= ~usb_clk_o; // R4 R6
    end
  end

  // ==========================================================================
  // system branch: fixed divide by three then postscaler
  logic [1:0] div3_q;
  logic [2:0] post_q;
  logic [2:0] post_last;

  assign post_last = (3'h1 << post_sel_q) - 3'h1; // R8

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div3_q     <= 2'h0;
      post_q     <= 3'h0;
      sys_tick_o <= 1'b0;
    end else begin
      sys_tick_o <= 1'b0;
      if (rise[1]) begin
        if (div3_q == DIV3_LAST) begin // R7
          div3_q <= 2'h0;
          if (post_q >= post_last) begin
            post_q     <= 3'h0;
            sys_tick_o <= 1'b1; // R5 R7
          end else begin
            post_q <= post_q + 3'h1;
          end
        end else begin
          div3_q <= div3_q + 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // half-rate clock output, only when that mode is enabled
  always_ff @(posedge clk_i) begin
    if (rst_i || !half_en_q) begin
      half_rate_clock_output_o <= 1'b0;
    end else if (sys_tick_o) begin
      half_rate_clock_output_o <= ~half_rate_clock_output_o; // R19
    end
  end

  // ==========================================================================
  // reference output: base from primary osc or system clock
  logic ref_run;
  logic base_tick;
  logic base_lvl;

  assign ref_run   = ref_q.out_en && (!sleep_i || ref_q.run_in_sleep); // R13 R16
  assign base_tick = ref_q.src_primary ? rise[0] : sys_tick_o; // R15
  assign base_lvl  = ref_q.src_primary ? s2_q[0] : sys_tick_o; // R15

  upr_ref_div u_ref_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (ref_run),
    .base_tick_i (base_tick),
    .base_lvl_i  (base_lvl),
    .div_sel_i   (ref_q.divisor_sel),
    .out_o       (refclk_output_pin_o)
  );

  // ==========================================================================
  // checks
  sequence pll_edge_s;
    rise[1] && usb_ok;
  endsequence

  usb_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (pll_edge_s ##1 usb_ok) |-> $changed(usb_clk_o)) else $error("usb clock missed a pll edge");
  usb_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    !usb_ok |=> !usb_clk_o) else $error("usb clock runs without primary pll");
  sys_div3_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    sys_tick_o |-> $past(rise[1]) && $past(div3_q) == DIV3_LAST) else $error("system tick off divide by three");
  ref_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (!ref_q.out_en ##1 !ref_q.out_en) |-> !refclk_output_pin_o) else $error("reference pin driven while off");
  sleep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (sleep_i && !ref_q.run_in_sleep) |=> !refclk_output_pin_o) else $error("reference runs in sleep");
  ref_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    (wb_ack_o && $past(wb_adr_i) == ADDR_REF_CTRL && !$past(wb_we_i)) |-> wb_dat_o[14] == 1'b0 && wb_dat_o[7:0] == 8'h00)
    else $error("reserved reference bits read nonzero");
  pre_tick_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    pll_ref_tick_o |-> $past(rise[0])) else $error("prescaler tick without oscillator edge");
  usb_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (usb_ok && !rise[1]) |=> $stable(usb_clk_o)) else $error("usb clock moved between pll edges");
  pre_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (rise[0] && pre_sel_q == 3'h0) |=> pll_ref_tick_o) else $error("prescaler code zero skipped an edge");
  ref_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (ref_run && ref_q.divisor_sel == 4'h0) |=> refclk_output_pin_o == $past(base_lvl))
    else $error("undivided reference does not follow its base");
  half_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    !half_en_q |=> !half_rate_clock_output_o) else $error("half-rate clock runs while disabled");
  // a held ack would let the standing request of a classic cycle be taken twice
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
  ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o) else $error("request not acknowledged in the next cycle");

endmodule : upr_clock_top
`default_nettype wire

// >>> rtl/upr_osc_unlock.sv
// oscillator control: keyed unlock of both bytes and the switch sequence
`timescale 1ns/100ps
`default_nettype none
module upr_osc_unlock (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wr_hi_i,
  input  wire logic                    wr_lo_i,
  input  wire logic                    wr_other_i,
  input  wire logic [7:0]              hi_byte_i,
  input  wire logic [7:0]              lo_byte_i,
  output var upr_pkg::upr_osc_state_t  state_o
);
  import upr_pkg::*;

  upr_key_state_t hi_q;
  upr_key_state_t lo_q;
  logic [2:0]     cur_q;
  logic [2:0]     new_q;
  logic           req_q;
  logic [3:0]     wait_q;
  logic           set_req;

  // ==========================================================================
  // high byte unlock: any write elsewhere breaks the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_other_i || wr_lo_i) begin
      hi_q <= KEY_IDLE;
    end else if (wr_hi_i) begin
      case (hi_q)
        KEY_IDLE:  hi_q <= (hi_byte_i == KEY_HI_FIRST) ? KEY_FIRST : KEY_IDLE; // R1
        KEY_FIRST: hi_q <= (hi_byte_i == KEY_HI_SECOND) ? KEY_OPEN : KEY_IDLE; // R1
        default:   hi_q <= KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      new_q <= OSC_RESET;
    end else if (wr_hi_i && hi_q == KEY_OPEN) begin
      new_q <= hi_byte_i[2:0]; // R20
    end
  end

  // ==========================================================================
  // low byte unlock
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_other_i || wr_hi_i) begin
      lo_q <= KEY_IDLE;
    end else if (wr_lo_i) begin
      case (lo_q)
        KEY_IDLE:  lo_q <= (lo_byte_i == KEY_LO_FIRST) ? KEY_FIRST : KEY_IDLE; // R3
        KEY_FIRST: lo_q <= (lo_byte_i == KEY_LO_SECOND) ? KEY_OPEN : KEY_IDLE; // R3
        default:   lo_q <= KEY_IDLE;
      endcase
    end
  end

  assign set_req = wr_lo_i && lo_q == KEY_OPEN && lo_byte_i[0]; // R2

  // ==========================================================================
  // switch: redundant request aborts, else wait then adopt new source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q  <= 1'b0;
      wait_q <= 4'h0;
      cur_q  <= OSC_RESET;
    end else if (set_req) begin
      req_q  <= 1'b1;
      wait_q <= 4'h0;
    end else if (req_q) begin
      if (new_q == cur_q) begin
        req_q <= 1'b0;
      end else if (wait_q == SWITCH_CYCLES - 4'h1) begin
        req_q <= 1'b0;
        cur_q <= new_q;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end

  assign state_o = '{cur_osc: cur_q, new_osc: new_q, switch_req: req_q};

  // ==========================================================================
  // checks
  hi_locked_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (hi_q != KEY_OPEN && wr_hi_i) |=> $stable(new_q)) else $error("new osc written while locked");
  lo_locked_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (!req_q && !(wr_lo_i && lo_q == KEY_OPEN)) |=> !req_q) else $error("switch started without unlock");
  switch_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    ($rose(req_q) && new_q != cur_q && !wr_lo_i && !wr_hi_i) |-> ##[9:10] (cur_q == new_q && !req_q))
    else $error("switch not completed in ten cycles");
  key_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (wr_hi_i && hi_q == KEY_IDLE && hi_byte_i == KEY_HI_FIRST && !wr_other_i && !wr_lo_i) |=> hi_q == KEY_FIRST)
    else $error("first key not taken");

endmodule : upr_osc_unlock
`default_nettype wire

// >>> rtl/upr_pkg.sv
// package: constants, register map and carriers of the usb pll and reference clock block
// Operation
// R1 - software unlocks high byte with 78h, 9Ah
// R2 - software sets switch request bit zero
// R3 - low byte unlocked by 46h, 57h first
// R4 - 48 MHz usb clock while usb enabled
// R5 - prescaler makes 4 MHz, feeds 96 MHz pll
// R6 - usb branch divides pll by two
// R7 - system branch divides by three, then postscaler
// R8 - postscaler codes give 32/16/8/4 MHz
// R9 - software avoids 8/4 MHz with usb on
// R10 - prescaler divisor set by three-bit field
// R11 - usb only from primary oscillator with pll
// R12 - rc with pll: 4/8 MHz, not usb
// R13 - bit 15 drives reference pin when set
// R14 - bits 11:8 divide base by power two
// R15 - bit 12 picks primary osc, else sysclk
// R16 - bit 13 keeps reference running in sleep
// R17 - software sets both bits for sleep output
// R18 - bit 14, bits 7:0 read zero; reset zero
// R19 - half-rate clock output in certain modes
// R20 - software switches source only when unlocked
// R21 - divider half duty, low while disabled
package upr_pkg;

  // ==========================================================================
  // register map (word aligned byte addresses)
  localparam logic [3:0]  ADDR_OSC_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_REF_CTRL  = 4'h4;
  localparam logic [3:0]  ADDR_CLK_CFG   = 4'h8;
  localparam logic [3:0]  ADDR_STATUS    = 4'hc;

  // ==========================================================================
  // unlock keys and switch timing
  localparam logic [7:0]  KEY_HI_FIRST   = 8'h78;
  localparam logic [7:0]  KEY_HI_SECOND  = 8'h9a;
  localparam logic [7:0]  KEY_LO_FIRST   = 8'h46;
  localparam logic [7:0]  KEY_LO_SECOND  = 8'h57;
  localparam logic [3:0]  SWITCH_CYCLES  = 4'ha;

  // ==========================================================================
  // oscillator codes
  localparam logic [2:0]  OSC_FRC        = 3'h0;
  localparam logic [2:0]  OSC_FRC_PLL    = 3'h1;
  localparam logic [2:0]  OSC_PRI        = 3'h2;
  localparam logic [2:0]  OSC_PRI_PLL    = 3'h3;
  localparam logic [2:0]  OSC_RESET      = OSC_FRC;

  // ==========================================================================
  // field positions
  localparam int          OSC_CUR_LSB    = 12;
  localparam int          OSC_NEW_LSB    = 8;
  localparam int          REF_EN_BIT     = 15;
  localparam int          REF_SLP_BIT    = 13;
  localparam int          REF_SRC_BIT    = 12;
  localparam int          REF_DIV_LSB    = 8;
  localparam int          CFG_PRE_LSB    = 0;
  localparam int          CFG_POST_LSB   = 4;
  localparam int          CFG_RC_LSB     = 8;
  localparam int          CFG_USB_BIT    = 12;
  localparam int          CFG_HALF_BIT   = 13;
  localparam logic [1:0]  DIV3_LAST      = 2'h2;
  localparam logic [14:0] REF_ONE        = 15'h0001;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       out_en;
    logic       run_in_sleep;
    logic       src_primary;
    logic [3:0] divisor_sel;
  } upr_ref_ctrl_t;

  typedef struct packed {
    logic [2:0] cur_osc;
    logic [2:0] new_osc;
    logic       switch_req;
  } upr_osc_state_t;

  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_FIRST = 2'b01,
    KEY_OPEN  = 2'b10
  } upr_key_state_t;

  // prescaler divisor minus one per code
  function automatic logic [3:0] upr_pre_last(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h0;
    case (code)
      3'h0: r = 4'h0;
      3'h1: r = 4'h1;
      3'h2: r = 4'h2;
      3'h3: r = 4'h3;
      3'h4: r = 4'h4;
      3'h5: r = 4'h5;
      3'h6: r = 4'h9;
      default: r = 4'hb;
    endcase
    return r;
  endfunction : upr_pre_last

endpackage : upr_pkg

// >>> rtl/upr_ref_div.sv
// reference clock divider: power-of-two divide of a base clock tick
`timescale 1ns/100ps
`default_nettype none
module upr_ref_div (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        base_tick_i,
  input  wire logic        base_lvl_i,
  input  wire logic [3:0]  div_sel_i,
  output logic             out_o
);
  import upr_pkg::*;

  logic [14:0] cnt_q;
  logic [14:0] half_last;

  // half period in base ticks, minus one
  assign half_last = (REF_ONE << (div_sel_i - 4'h1)) - REF_ONE;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= 15'h0000;
      out_o <= 1'b0; // R21
    end else if (div_sel_i == 4'h0) begin
      cnt_q <= 15'h0000;
      out_o <= base_lvl_i; // R14
    end else if (base_tick_i) begin
      if (cnt_q >= half_last) begin
        cnt_q <= 15'h0000;
        out_o <= ~out_o; // R14 R21
      end else begin
        cnt_q <= cnt_q + REF_ONE;
      end
    end
  end

  idle_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    !run_i |=> !out_o) else $error("reference output not low while stopped");
  div_two_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (run_i && div_sel_i == 4'h1 && base_tick_i && $past(run_i) && $past(div_sel_i) == 4'h1) |=> $changed(out_o))
    else $error("divide by two did not toggle on every base tick");

endmodule : upr_ref_div
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the usb pll and reference clock block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import upr_pkg::*;
  // ==========================================================================
  // clock, bus and pins
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dw    = 32'h0;
  logic        slp   = 1'b0;
  logic [31:0] dr;
  logic        ack, pri, pll, pre_t, usb, sys_t, rpin, half, usb_q, half_q;
  logic [15:0] rises;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          n_usb, n_sys, n_pre, n_half;
  localparam logic [31:0] OSC_PP = (32'(OSC_PRI_PLL) << OSC_CUR_LSB) | (32'(OSC_PRI_PLL) << OSC_NEW_LSB);
  always #4 clk_i = ~clk_i;

  upr_clock_top upr_clock_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .primary_osc_i(pri),
    .pll_out_i(pll), .sleep_i(slp), .pll_ref_tick_o(pre_t), .usb_clk_o(usb), .sys_tick_o(sys_t),
    .refclk_output_pin_o(rpin), .half_rate_clock_output_o(half));
  upr_ext_model upr_ext_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ref_i(rpin), .primary_o(pri), .pll_o(pll),
    .ref_rises_o(rises));

  // ==========================================================================
  // output event counters, cleared by reset
  always @(posedge clk_i) begin
    usb_q  <= usb;
    half_q <= half;
    if (rst_i) begin
      {n_usb, n_sys, n_pre, n_half} <= '0;
    end else begin
      n_usb  <= n_usb + int'(usb !== usb_q);
      n_half <= n_half + int'(half !== half_q);
      n_sys  <= n_sys + int'(sys_t === 1'b1);
      n_pre  <= n_pre + int'(pre_t === 1'b1);
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // classic single cycle; no latency assumed, a wait ends on ack or after 50 cycles
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    i = 0;
    {cyc, stb, we, adr, sel, dw} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = dr;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      n_errors++;
      results();
    end
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : reset_dut

  // single-byte writes only: a two-byte write would break both key sequences
  task automatic switch_to(input logic [7:0] k2, input logic [2:0] osc);
    logic [31:0] q;
    int i;
    wr(ADDR_OSC_CTRL, 4'h2, {16'h0, KEY_HI_FIRST, 8'h0});
    wr(ADDR_OSC_CTRL, 4'h2, {16'h0, k2, 8'h0});
    wr(ADDR_OSC_CTRL, 4'h2, {21'h0, osc, 8'h0});
    wr(ADDR_OSC_CTRL, 4'h1, {24'h0, KEY_LO_FIRST});
    wr(ADDR_OSC_CTRL, 4'h1, {24'h0, KEY_LO_SECOND});
    wr(ADDR_OSC_CTRL, 4'h1, 32'h1);
    i = 0;
    do begin
      wb(1'b0, ADDR_OSC_CTRL, 4'hf, 32'h0, q);
      i++;
    end while (q[0] !== 1'b0 && i < 20);
    if (q[0] !== 1'b0) begin
      n_errors++;
      results();
    end
    chk(q, OSC_PP);
  endtask : switch_to

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    reset_dut();
    rd(ADDR_OSC_CTRL, 32'h0);
    rd(ADDR_REF_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_REF_CTRL, 4'hf, 32'hffff_ffff);
    rd(ADDR_REF_CTRL, 32'h0000_bf00);
    rd(4'h6, 32'h0);
  endtask : t_regs

  task automatic t_usb();
    logic [31:0] u;
    int b;
    u = (32'h1 << CFG_USB_BIT) | (32'h1 << CFG_RC_LSB) | (32'h1 << CFG_POST_LSB);
    reset_dut();
    wr(ADDR_CLK_CFG, 4'hf, u);
    rd(ADDR_CLK_CFG, u);
    upr_ext_model_inst.burst(1'b1, 10);
    chk(n_usb, 0);
    switch_to(KEY_HI_SECOND, OSC_PRI_PLL);
    switch_to(8'h55, OSC_FRC);
    b = n_usb;
    upr_ext_model_inst.burst(1'b1, 10);
    chk(n_usb - b, 10);
    rd(ADDR_STATUS, 32'h3);
  endtask : t_usb

  task automatic t_sys();
    for (int p = 0; p < 4; p++) begin
      reset_dut();
      wr(ADDR_CLK_CFG, 4'hf, (32'(p) << CFG_POST_LSB) | (32'h1 << CFG_HALF_BIT));
      upr_ext_model_inst.burst(1'b1, 24);
      chk(n_sys, 24 / (3 << p));
      chk(n_half, 24 / (3 << p));
    end
  endtask : t_sys

  task automatic t_pre();
    int dv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    for (int c = 0; c < 8; c++) begin
      reset_dut();
      wr(ADDR_CLK_CFG, 4'hf, 32'(c));
      upr_ext_model_inst.burst(1'b0, 60);
      chk(n_pre, 60 / dv[c]);
      chk(rises, 0);
    end
  endtask : t_pre

  task automatic t_ref(input logic [31:0] c, input logic s, input logic p, input int n, input int lo, input int hi);
    reset_dut();
    slp <= s;
    wr(ADDR_REF_CTRL, 4'hf, c);
    upr_ext_model_inst.burst(p, n);
    chk(32'(rises >= lo && rises <= hi), 32'h1);
    slp <= 1'b0;
  endtask : t_ref

  // ==========================================================================
  // main sequence
  initial begin
    @(posedge clk_i);
    t_regs();
    t_usb();
    t_sys();
    t_pre();
    t_ref(32'h9200, 1'b0, 1'b0, 32, 7, 8);
    t_ref(32'h9000, 1'b0, 1'b0, 32, 32, 32);
    t_ref(32'h9200, 1'b1, 1'b0, 32, 0, 0);
    t_ref(32'hb200, 1'b1, 1'b0, 32, 7, 8);
    t_ref(32'h8000, 1'b0, 1'b1, 24, 8, 8);
    results();
  end
endmodule : tb_top
`default_nettype wire

// >>> testbench/upr_ext_model.sv
// far-side model: primary oscillator and pll pin sources, reference pin load
`timescale 1ns/100ps
`default_nettype none
module upr_ext_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ref_i,
  output var  logic        primary_o,
  output var  logic        pll_o,
  output var  logic [15:0] ref_rises_o
);
  // ==========================================================================
  // reference pin load: counts rising edges it is clocked by
  logic ref_q;
  initial begin
    primary_o = 1'b0;
    pll_o     = 1'b0;
    ref_q     = 1'b0;
  end
  always @(posedge clk_i) begin
    ref_q <= ref_i;
    if (rst_i) begin
      ref_rises_o <= 16'h0000;
    end else if (ref_i && !ref_q) begin
      ref_rises_o <= ref_rises_o + 16'h0001;
    end
  end
  // ==========================================================================
  // source pulses
  // three high, three low: slower than clk/4 so the sampled pins see every edge
  // lines stand low between bursts, as a stopped clock would
  task automatic burst(input logic pll, input int n);
    repeat (n) begin
      if (pll) pll_o <= 1'b1;
      else primary_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      {pll_o, primary_o} <= 2'b00;
      repeat (3) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask : burst
endmodule : upr_ext_model
`default_nettype wire
